// File: rtl/dcp_top.sv
// dma checksum engine and per-level arbitration control with apb slave
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "dcp_consts.svh"
module dcp_top #(
   parameter int CHANNELS = 16
) (
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output logic [31:0]               prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire dcp_pkg::dcp_beat_in_t dma_beat,
   input  wire logic                 dma_done,
   input  wire logic [3:0]           dma_done_ch,
   input  wire logic [4*CHANNELS-1:0] pend_by_level,
   output logic [3:0]                grant_vld,
   output logic [15:0]               grant_ch,
   output logic                      crc_busy
);
   import dcp_pkg::*;
   initial begin
      if (CHANNELS < 1 || CHANNELS > 16) $error("CHANNELS must be 1..16");
   end

   logic [31:0] prictrl_reg;
   logic [15:0] ckctrl_reg;
   dcp_state_t  state_reg;
   logic [31:0] result_reg;
   logic        crc_unit_busy;
   logic [31:0] crc_val;
   logic [3:0]  arb_vld;
   logic [15:0] arb_ch;
   logic        wr_en;
   logic        rd_en;
   logic        cpu_load;
   logic        dma_load;
   logic        restart;
   logic [2:0]  cpu_bytes;
   logic [2:0]  dma_bytes;
   logic        pend_load_reg;
   logic [31:0] pend_data_reg;
   logic [2:0]  pend_bytes_reg;

   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;

   // beat width to byte count
   function automatic logic [2:0] beat_bytes(input dcp_beat_t b);
      unique case (b)
         DCP_BEAT_BYTE: beat_bytes = 3'h1;
         DCP_BEAT_HALF: beat_bytes = 3'h2;
         DCP_BEAT_WORD: beat_bytes = 3'h4;
         default:       beat_bytes = 3'h4;
      endcase
   endfunction
   assign cpu_bytes = beat_bytes(dcp_beat_t'(ckctrl_reg[`DCP_CTL_BEAT_LSB +: 2]));
   assign dma_bytes = beat_bytes(dma_beat.beat);

   // cpu data-input writes, also the dma destination path
   assign cpu_load = wr_en && paddr == `DCP_OFS_CKDATA;
   // channel-sourced beats when the source is enabled
   assign dma_load = ckctrl_reg[`DCP_CTL_SRCEN_BIT] && dma_beat.valid &&
                     dma_beat.channel == ckctrl_reg[`DCP_CTL_SRC_LSB +: 4];
   assign restart  = wr_en && paddr == `DCP_OFS_CKCLEAR;

   // hold one beat while the engine is folding; relies on paced source
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_load_reg  <= 1'b0;
         pend_data_reg  <= 32'h00000000;
         pend_bytes_reg <= 3'h0;
      end else if (cpu_load || dma_load) begin
         // a beat in the restart cycle is kept: the engine restarts first, then folds it
         pend_load_reg  <= 1'b1;
         pend_data_reg  <= cpu_load ? pwdata : dma_beat.data;
         pend_bytes_reg <= cpu_load ? cpu_bytes : dma_bytes;
      end else if (restart) begin
         pend_load_reg <= 1'b0;
      end else if (!crc_unit_busy) begin
         pend_load_reg <= 1'b0;
      end
   end

   dcp_crc_unit u_crc (
      .clk       (clk),
      .rst_n     (rst_n),
      .restart   (restart),
      .use_crc32 (ckctrl_reg[`DCP_CTL_POLY_BIT]),
      .load      (pend_load_reg),
      .load_data (pend_data_reg),
      .load_bytes(pend_bytes_reg),
      .busy      (crc_unit_busy),
      .crc       (crc_val)
   );

   // checksum control register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ckctrl_reg <= 16'h0000;
      end else if (wr_en && paddr == `DCP_OFS_CKCTRL) begin
         ckctrl_reg <= pwdata[15:0] & 16'h8F07;
      end
   end

   // result state: latched when the source channel ends
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg  <= DCP_ST_IDLE;
         result_reg <= 32'h00000000;
      end else begin
         unique case (state_reg)
            DCP_ST_IDLE: begin
               if (dma_load || cpu_load) begin
                  state_reg <= DCP_ST_RUN;
               end
            end
            DCP_ST_RUN: begin
               if (dma_done && dma_done_ch == ckctrl_reg[`DCP_CTL_SRC_LSB +: 4] &&
                   !crc_unit_busy && !pend_load_reg) begin
                  state_reg  <= DCP_ST_DONE;
                  result_reg <= crc_val;
               end else if (restart) begin
                  state_reg <= DCP_ST_IDLE;
               end
            end
            DCP_ST_DONE: begin
               if (restart) begin
                  state_reg <= DCP_ST_IDLE;
               end
            end
            default: state_reg <= DCP_ST_IDLE;
         endcase
      end
   end

   // arbiters, one per level
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_lvl
         dcp_level_arb #(.CHANNELS(CHANNELS)) u_arb (
            .clk      (clk),
            .rst_n    (rst_n),
            .rr_en    (prictrl_reg[g*`DCP_LVL_STRIDE + `DCP_RR_BIT]),
            .last_ch  (prictrl_reg[g*`DCP_LVL_STRIDE +: 4]),
            .pend     (pend_by_level[g*CHANNELS +: CHANNELS]),
            .grant_vld(arb_vld[g]),
            .grant_ch (arb_ch[g*4 +: 4])
         );
      end
   endgenerate

   // priority control: sw write, hw records the last rr grant
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prictrl_reg <= 32'h00000000;
      end else begin
         for (int l = 0; l < 4; l++) begin
            if (wr_en && paddr == `DCP_OFS_PRICTRL) begin
               // only the select bit and field are writable
               prictrl_reg[l*8 + 7] <= pwdata[l*8 + 7];
               prictrl_reg[l*8 +: 4] <= pwdata[l*8 +: 4];
            end
            // grant recording wins over a simultaneous write
            if (prictrl_reg[l*8 + 7] && arb_vld[l]) begin
               prictrl_reg[l*8 +: 4] <= arb_ch[l*4 +: 4];
            end
         end
      end
   end

   // registered grant and busy outputs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         grant_vld <= 4'h0;
         grant_ch  <= 16'h0000;
         crc_busy  <= 1'b0;
      end else begin
         grant_vld <= arb_vld;
         grant_ch  <= arb_ch;
         crc_busy  <= crc_unit_busy || pend_load_reg || cpu_load || dma_load;
      end
   end

   // apb: zero-wait, reads registered on the edge that ends setup
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= 1'b0;
         if (psel && !penable && !pwrite) begin
            unique case (paddr)
               `DCP_OFS_PRICTRL:  prdata <= prictrl_reg;
               `DCP_OFS_CKCTRL:   prdata <= {16'h0000, ckctrl_reg};
               `DCP_OFS_CKSTATUS: prdata <= {29'h0, state_reg == DCP_ST_DONE, 1'b0, crc_busy};
               `DCP_OFS_CKRESULT: prdata <= (state_reg == DCP_ST_DONE) ? result_reg : crc_val;
               default:           prdata <= 32'h00000000;
            endcase
         end
         if (psel && !penable) begin
            pslverr <= !(paddr inside {`DCP_OFS_PRICTRL, `DCP_OFS_CKCTRL, `DCP_OFS_CKDATA,
                                       `DCP_OFS_CKSTATUS, `DCP_OFS_CKRESULT, `DCP_OFS_CKCLEAR});
         end
      end
   end

   a_rr_record: assert property (@(posedge clk) disable iff (!rst_n)
      (prictrl_reg[31] && arb_vld[3]) |=> prictrl_reg[27:24] == $past(arb_ch[15:12]))
      else $error("level 3 last grant not recorded");
   a_field_kept: assert property (@(posedge clk) disable iff (!rst_n)
      (!prictrl_reg[23] && !(wr_en && paddr == `DCP_OFS_PRICTRL)) |=> $stable(prictrl_reg[19:16]))
      else $error("level 2 field changed in static mode");
   a_static_low: assert property (@(posedge clk) disable iff (!rst_n)
      (!prictrl_reg[7] && pend_by_level[0]) |-> arb_vld[0] && arb_ch[3:0] == 4'h0)
      else $error("static pick ignored channel 0");
   a_result_hold: assert property (@(posedge clk) disable iff (!rst_n)
      (state_reg == DCP_ST_DONE && !restart) |=> $stable(result_reg))
      else $error("final checksum changed");
   a_busy_flag: assert property (@(posedge clk) disable iff (!rst_n)
      cpu_load |=> crc_busy)
      else $error("busy not shown after data write");
endmodule // dcp_top
`default_nettype wire

// File: rtl/dcp_consts.svh
// constants for the dma checksum and priority arbitration block
// Notes on behaviour
// - crc16 and crc32 on any channel
// - selected channel feeds every moved item
// - final checksum readable after complete/abort
// - data input usable as dma destination
// - beat size picks 8, 16, 32 bits
// - any byte count folded byte by byte
// - one byte per cycle
// - per level bit: static or round-robin
// - field holds last granted channel
// - static order ignores the field
// - clearing select keeps the field
// - select bits 31/23/15/7, field below
`ifndef DCP_CONSTS_SVH
`define DCP_CONSTS_SVH
`define DCP_OFS_PRICTRL   12'h000
`define DCP_OFS_CKCTRL    12'h004
`define DCP_OFS_CKDATA    12'h008
`define DCP_OFS_CKSTATUS  12'h00C
`define DCP_OFS_CKRESULT  12'h010
`define DCP_OFS_CKCLEAR   12'h014
`define DCP_RR_BIT        7
`define DCP_LVL_STRIDE    8
`define DCP_CTL_BEAT_LSB  0
`define DCP_CTL_POLY_BIT  2
`define DCP_CTL_SRC_LSB   8
`define DCP_CTL_SRCEN_BIT 15
`define DCP_CRC16_POLY    32'h00001021
`define DCP_CRC32_POLY    32'hEDB88320
`define DCP_CRC16_INIT    32'h0000FFFF
`define DCP_CRC32_INIT    32'hFFFFFFFF
`endif

// File: rtl/dcp_pkg.sv
// types shared by the checksum and arbitration block
package dcp_pkg;
   typedef enum logic [1:0] {
      DCP_BEAT_BYTE = 2'b00,
      DCP_BEAT_HALF = 2'b01,
      DCP_BEAT_WORD = 2'b10
   } dcp_beat_t;
   typedef enum logic [1:0] {
      DCP_ST_IDLE = 2'b00,
      DCP_ST_RUN  = 2'b01,
      DCP_ST_DONE = 2'b11
   } dcp_state_t;
   typedef struct packed {
      logic        valid;
      logic [3:0]  channel;
      logic [31:0] data;
      dcp_beat_t   beat;
   } dcp_beat_in_t;
endpackage

// File: rtl/dcp_crc_unit.sv
// byte-serial crc16/crc32 engine
`timescale 1ns/1ps
`default_nettype none
`include "dcp_consts.svh"
module dcp_crc_unit (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              restart,
   input  wire logic              use_crc32,
   input  wire logic              load,
   input  wire logic [31:0]       load_data,
   input  wire logic [2:0]        load_bytes,
   output logic                   busy,
   output logic [31:0]            crc
);
   import dcp_pkg::*;
   logic [31:0] shift_reg;
   logic [2:0]  left_reg;
   logic [31:0] crc_reg;
   logic [31:0] crc_next;
   // fold one byte, msb-first for crc16, reflected for crc32
   always_comb begin
      crc_next = crc_reg;
      if (use_crc32) begin
         crc_next = crc_reg ^ {24'h000000, shift_reg[7:0]};
         for (int i = 0; i < 8; i++) begin
            crc_next = crc_next[0] ? ((crc_next >> 1) ^ `DCP_CRC32_POLY) : (crc_next >> 1);
         end
      end else begin
         crc_next = crc_reg ^ {16'h0000, shift_reg[7:0], 8'h00};
         for (int i = 0; i < 8; i++) begin
            crc_next = crc_next[15] ? {16'h0000, crc_next[14:0], 1'b0} ^ `DCP_CRC16_POLY
                                    : {16'h0000, crc_next[14:0], 1'b0};
         end
      end
   end
   // one byte per cycle, low byte first
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shift_reg <= 32'h00000000;
         left_reg  <= 3'h0;
         crc_reg   <= `DCP_CRC16_INIT;
      end else if (restart) begin
         left_reg <= 3'h0;
         crc_reg  <= use_crc32 ? `DCP_CRC32_INIT : `DCP_CRC16_INIT;
      end else if (load && left_reg == 3'h0) begin
         shift_reg <= load_data;
         left_reg  <= load_bytes;
      end else if (left_reg != 3'h0) begin
         crc_reg   <= crc_next;
         shift_reg <= {8'h00, shift_reg[31:8]};
         left_reg  <= left_reg - 3'h1;
      end
   end
   assign busy = (left_reg != 3'h0);
   assign crc  = use_crc32 ? ~crc_reg : crc_reg;
   a_byte_count: assert property (@(posedge clk) disable iff (!rst_n)
      (load && !busy && !restart && load_bytes == 3'h4) |=> busy [*4] ##1 !busy)
      else $error("word load did not take four cycles");
endmodule // dcp_crc_unit
`default_nettype wire

// File: rtl/dcp_level_arb.sv
// one priority level: static or round-robin channel pick
`timescale 1ns/1ps
`default_nettype none
module dcp_level_arb #(
   parameter int CHANNELS = 16
) (
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire logic                rr_en,
   input  wire logic [3:0]          last_ch,
   input  wire logic [CHANNELS-1:0] pend,
   output logic                     grant_vld,
   output logic [3:0]               grant_ch
);
   initial begin
      if (CHANNELS < 1 || CHANNELS > 16) $error("CHANNELS must be 1..16");
   end
   // static: lowest number wins; rr: first pending after last
   always_comb begin
      logic [4:0] idx;
      logic       found;
      idx = 5'h00;
      found = 1'b0;
      grant_vld = 1'b0;
      grant_ch = 4'h0;
      for (int k = 1; k <= CHANNELS; k++) begin
         idx = rr_en ? 5'((int'(last_ch) + k) % CHANNELS) : 5'(k - 1);
         if (!found && pend[idx[3:0]]) begin
            found = 1'b1;
            grant_vld = 1'b1;
            grant_ch = idx[3:0];
         end
      end
   end
   a_grant_pending: assert property (@(posedge clk) disable iff (!rst_n)
      grant_vld |-> pend[grant_ch])
      else $error("grant to channel without request");
endmodule // dcp_level_arb
`default_nettype wire

// File: dv/dcp_dma_model.sv
// far-side model: dma channel moving items and ending transactions
`timescale 1ns/1ps
`default_nettype none
module dcp_dma_model (
   input  wire logic             clk,
   output dcp_pkg::dcp_beat_in_t beat,
   output logic                  done,
   output logic [3:0]            done_ch
);
   import dcp_pkg::*;
   // quiet bus at time zero
   initial begin
      beat = '0;
      done = 1'b0;
      done_ch = 4'h0;
   end
   // one moved word; released fields show the inverse so stale data cannot match
   task automatic send(input logic [3:0] ch, input logic [31:0] d);
      @(posedge clk);
      beat <= '{1'b1, ch, d, DCP_BEAT_WORD};
      @(posedge clk);
      beat <= '{1'b0, ~ch, ~d, DCP_BEAT_WORD};
      repeat (3) @(posedge clk); // room for four byte folds
   endtask
   // end of a channel transaction, completed or aborted
   task automatic finish(input logic [3:0] ch);
      @(posedge clk);
      done <= 1'b1;
      done_ch <= ch;
      @(posedge clk);
      done <= 1'b0;
      done_ch <= ~ch;
   endtask
endmodule // dcp_dma_model
`default_nettype wire

// File: dv/dcp_top_test.sv
// self-checking bench for the checksum and arbitration block
`timescale 1ns/1ps
`default_nettype none
`include "dcp_consts.svh"
module dcp_top_test;
   import dcp_pkg::*;
   logic          clk, rst_n, psel, penable, pwrite, pready, pslverr, dma_done, crc_busy;
   logic [11:0]   paddr;
   logic [31:0]   pwdata, prdata, d, c32;
   logic [15:0]   c16, grant_ch;
   logic [3:0]    dma_done_ch, grant_vld;
   logic [63:0]   pend;
   logic [32:0]   exp_q[$];
   dcp_beat_in_t  dma_beat;
   int            mismatches, num_checks, cyc, nb;
   dcp_top i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .dma_beat(dma_beat), .dma_done(dma_done), .dma_done_ch(dma_done_ch), .pend_by_level(pend),
      .grant_vld(grant_vld), .grant_ch(grant_ch), .crc_busy(crc_busy));
   dcp_dma_model i_dma (.clk(clk), .beat(dma_beat), .done(dma_done), .done_ch(dma_done_ch));
   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic check(input string nm, input logic [32:0] e, input logic [32:0] s);
      num_checks++;
      if (s !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // hang guard, generous against the few hundred cycles needed
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         wrap_up();
      end
   end
   // read monitor: each answered read takes the oldest note
   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         if (exp_q.size() == 0) check("unexpected read", 33'h0, {pslverr, prdata});
         else check("apb read", exp_q.pop_front(), {pslverr, prdata});
      end
   end
   // apb master: setup, then hold access until pready is seen
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dv);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= dv;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] dv);
      apb(1'b1, a, dv);
   endtask
   task automatic rd(input logic [11:0] a, input logic [32:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   // software polls busy before the next data word, bounded
   task automatic wait_idle();
      int n;
      repeat (2) @(posedge clk);
      n = 0;
      while (crc_busy !== 1'b0 && n < 100) begin
         @(posedge clk);
         n++;
      end
   endtask
   // one-cycle request pulse, grant looked at once it has landed
   task automatic arb(input logic [63:0] p, input int lvl, input logic [3:0] ch);
      @(posedge clk);
      pend <= p;
      @(posedge clk);
      pend <= 64'h0;
      @(negedge clk);
      check("grant", {28'h0, 1'b1, ch}, {28'h0, grant_vld[lvl], grant_ch[4*lvl +: 4]});
   endtask
   function automatic logic [15:0] f16(input logic [15:0] c, input logic [7:0] b);
      c ^= {b, 8'h00};
      for (int i = 0; i < 8; i++) c = c[15] ? ((c << 1) ^ 16'h1021) : (c << 1);
      return c;
   endfunction
   function automatic logic [31:0] f32(input logic [31:0] c, input logic [7:0] b);
      c ^= {24'h0, b};
      for (int i = 0; i < 8; i++) c = c[0] ? ((c >> 1) ^ 32'hEDB88320) : (c >> 1);
      return c;
   endfunction
   // main sequence
   initial begin
      {psel, penable, pwrite, paddr, pwdata, pend} = '0;
      rst_n = 1'b0;
      void'($urandom(32'h9a39));
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd(`DCP_OFS_PRICTRL, 33'h0);
      wr(`DCP_OFS_PRICTRL, 32'h8F8F8F8F);
      rd(`DCP_OFS_PRICTRL, {1'b0, 32'h8F8F8F8F});
      // level 3 rotation after channel 15 wraps to the first pending, channel 4
      arb(64'h0030_0000_0000_0000, 3, 4'h4);
      rd(12'h040, {1'b1, 32'h0});
      // static level 0 with a nonzero field: lowest pending wins
      wr(`DCP_OFS_PRICTRL, 32'h00000007);
      arb(64'h0000_0000_0000_0224, 0, 4'h2);
      arb(64'h0000_0000_0000_0011, 0, 4'h0);
      // rotation on level 1 after channel 2: channel 5 is next
      wr(`DCP_OFS_PRICTRL, 32'h00008200);
      arb(64'h0000_0000_0022_0000, 1, 4'h5);
      rd(`DCP_OFS_PRICTRL, {1'b0, 32'h00008500});
      // cpu feed at each beat size, crc16
      for (int b = 0; b < 3; b++) begin
         nb = (b == 0) ? 1 : (b == 1) ? 2 : 4;
         wr(`DCP_OFS_CKCLEAR, 32'h0);
         wr(`DCP_OFS_CKCTRL, b);
         c16 = 16'hFFFF;
         repeat (2) begin
            d = $urandom();
            wr(`DCP_OFS_CKDATA, d);
            for (int k = 0; k < nb; k++) c16 = f16(c16, d[8*k +: 8]);
            rd(`DCP_OFS_CKSTATUS, {1'b0, 32'h00000001});
            wait_idle();
         end
         rd(`DCP_OFS_CKRESULT, {17'h0, c16});
      end
      // dma feed from channel 3, crc32, channel 5 traffic must not count
      // restart takes its start value from the selected polynomial, so select first
      wr(`DCP_OFS_CKCTRL, 32'h00008306);
      wr(`DCP_OFS_CKCLEAR, 32'h0);
      c32 = 32'hFFFFFFFF;
      repeat (3) begin
         d = $urandom();
         i_dma.send(4'h3, d);
         i_dma.send(4'h5, ~d);
         for (int k = 0; k < 4; k++) c32 = f32(c32, d[8*k +: 8]);
      end
      i_dma.finish(4'h3);
      wait_idle();
      rd(`DCP_OFS_CKSTATUS, {1'b0, 32'h00000004});
      rd(`DCP_OFS_CKRESULT, {1'b0, ~c32});
      repeat (4) @(posedge clk);
      check("notes left", 33'h0, 33'(exp_q.size()));
      wrap_up();
   end
endmodule // dcp_top_test
`default_nettype wire
